//--- rtl/aocr_pkg.sv
// shared constants and types for the output test and configuration register bank
// Operation
// R1: pattern sequencing 00 repeats, 01 alternates
// R2: sequencing acts only in user pattern mode
// R3: mode code 1000 selects user pattern
// R4: phase bits 6:4 delay in input clocks
// R5: drive bit 0: 0 normal, 1 doubled
// R6: nonzero mode replaces samples with test data
package aocr_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam logic [ADDR_W-1:0] ADDR_ENH = 13'h000c;
  localparam logic [ADDR_W-1:0] ADDR_TEST = 13'h000d;
  localparam logic [ADDR_W-1:0] ADDR_OFFS = 13'h0010;
  localparam logic [ADDR_W-1:0] ADDR_FMT = 13'h0014;
  localparam logic [ADDR_W-1:0] ADDR_DRV = 13'h0015;
  localparam logic [ADDR_W-1:0] ADDR_PHASE = 13'h0016;
  localparam logic [ADDR_W-1:0] ADDR_VREF = 13'h0018;
  localparam logic [ADDR_W-1:0] ADDR_PAT1L = 13'h0019;

  localparam logic [7:0] RST_ENH = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_OFFS = 8'h00;
  localparam logic [7:0] RST_FMT = 8'h01;
  localparam logic [7:0] RST_DRV = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h03;
  localparam logic [7:0] RST_VREF = 8'h04;
  localparam logic [7:0] RST_PAT1L = 8'h00;

  // field positions
  localparam int unsigned CHOP_BIT = 2;
  localparam int unsigned SEQ_LSB = 6;
  localparam int unsigned PNL_BIT = 5;
  localparam int unsigned PNS_BIT = 4;
  localparam int unsigned IEEE_BIT = 6;
  localparam int unsigned INV_BIT = 2;
  localparam int unsigned TWOS_BIT = 0;
  localparam int unsigned TERM_LSB = 4;
  localparam int unsigned DRV_BIT = 0;
  localparam int unsigned PH_IN_LSB = 4;

  // test mode selector codes
  localparam logic [3:0] TM_OFF = 4'h0;
  localparam logic [3:0] TM_MID = 4'h1;
  localparam logic [3:0] TM_POSFS = 4'h2;
  localparam logic [3:0] TM_NEGFS = 4'h3;
  localparam logic [3:0] TM_CHECK = 4'h4;
  localparam logic [3:0] TM_PNLONG = 4'h5;
  localparam logic [3:0] TM_PNSHORT = 4'h6;
  localparam logic [3:0] TM_TOGGLE = 4'h7;
  localparam logic [3:0] TM_USER = 4'h8;
  localparam logic [1:0] SEQ_SINGLE = 2'h0;
  localparam logic [1:0] SEQ_ALT = 2'h1;
  localparam logic [1:0] SEQ_SINGLE_ONCE = 2'h2;
  localparam logic [1:0] SEQ_ALT_ONCE = 2'h3;

  // serial port framing
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam int unsigned RW_BIT = 15;

  typedef enum logic [1:0] {SPI_IDLE, SPI_INSTR, SPI_DATA} aocr_spi_e;

  typedef struct packed {
    logic chop_en;
    logic ieee_range;
    logic twos_comp;
    logic drive_double;
    logic [1:0] term_sel;
    logic [2:0] clk_phase_in;
    logic [3:0] clk_phase_out;
    logic [2:0] vref_sel;
    logic [1:0] pat_seq;
    logic pn_long_rst;
    logic pn_short_rst;
    logic [7:0] user_pattern_one_low;
  } aocr_cfg_s;

  typedef struct packed {
    logic [3:0] test_mode;
    logic [7:0] offset_trim;
    logic invert;
  } aocr_chan_cfg_s;
endpackage : aocr_pkg

//--- rtl/aocr_tpg.sv
// one channel's output source: converted samples or the selected test pattern
module aocr_tpg #(
  parameter int unsigned DW = 12
) (
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic sample_valid_i, // one new output word per pulse
  input wire logic [DW-1:0] sample_i, // converted sample, offset binary
  input wire aocr_pkg::aocr_chan_cfg_s chan_i, // per-channel settings
  input wire aocr_pkg::aocr_cfg_s cfg_i, // global settings
  input wire logic [15:0] pat1_i, // user pattern one
  input wire logic [15:0] pat2_i, // user pattern two
  output logic [DW-1:0] data_o // word to the serializer
);
  import aocr_pkg::*;

  logic [DW-1:0] data_d, data_q;
  logic alt_d, alt_q, done_d, done_q;
  logic [22:0] pnl_d, pnl_q;
  logic [8:0] pns_d, pns_q;
  logic [DW-1:0] ramp_d, ramp_q;
  logic [DW-1:0] norm;
  logic [DW-1:0] user_w;
  logic is_user;

  assign is_user = (chan_i.test_mode == TM_USER); // R3

  always_comb
  begin
    norm = cfg_i.twos_comp ? {~sample_i[DW-1], sample_i[DW-2:0]} : sample_i;
    norm = chan_i.invert ? ~norm : norm;
    user_w = alt_q ? pat2_i[15 -: DW] : pat1_i[15 -: DW];
    data_d = data_q;
    alt_d = alt_q;
    done_d = done_q;
    pnl_d = cfg_i.pn_long_rst ? '1 : pnl_q;
    pns_d = cfg_i.pn_short_rst ? '1 : pns_q;
    ramp_d = ramp_q;
    if (!is_user)
    begin
      done_d = 1'b0; // R2
    end
    if (sample_valid_i)
    begin
      alt_d = ~alt_q;
      ramp_d = ramp_q + 1'b1;
      if (!cfg_i.pn_long_rst)
        pnl_d = {pnl_q[21:0], pnl_q[22] ^ pnl_q[17]};
      if (!cfg_i.pn_short_rst)
        pns_d = {pns_q[7:0], pns_q[8] ^ pns_q[4]};
      case (chan_i.test_mode) // R6
        TM_OFF: data_d = norm;
        TM_MID: data_d = {1'b1, {(DW-1){1'b0}}};
        TM_POSFS: data_d = '1;
        TM_NEGFS: data_d = '0;
        TM_CHECK: data_d = alt_q ? {(DW/2){2'b01}} : {(DW/2){2'b10}};
        TM_PNLONG: data_d = pnl_q[DW-1:0];
        TM_PNSHORT: data_d = {{(DW-9){1'b0}}, pns_q};
        TM_TOGGLE: data_d = alt_q ? '0 : '1;
        TM_USER:
        begin
          case (cfg_i.pat_seq) // R1 R2
            SEQ_SINGLE:
            begin
              data_d = pat1_i[15 -: DW];
              alt_d = 1'b0;
            end
            SEQ_ALT: data_d = user_w;
            SEQ_SINGLE_ONCE:
            begin
              data_d = done_q ? '0 : pat1_i[15 -: DW];
              alt_d = 1'b0;
              done_d = 1'b1;
            end
            default:
            begin
              data_d = done_q ? '0 : user_w;
              done_d = done_q | alt_q;
            end
          endcase
        end
        default: data_d = ramp_q;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_q <= '0;
      alt_q <= 1'b0;
      done_q <= 1'b0;
      pnl_q <= '1;
      pns_q <= '1;
      ramp_q <= '0;
    end
    else
    begin
      data_q <= data_d;
      alt_q <= alt_d;
      done_q <= done_d;
      pnl_q <= pnl_d;
      pns_q <= pns_d;
      ramp_q <= ramp_d;
    end
  end

  assign data_o = data_q;

  AST_USER_SINGLE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R1
    sample_valid_i && is_user && cfg_i.pat_seq == SEQ_SINGLE |=> data_o == $past(pat1_i[15 -: DW]))
    else $error("single user pattern not repeated");
  AST_USER_ALT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R1
    sample_valid_i && is_user && cfg_i.pat_seq == SEQ_ALT && alt_q
    |=> data_o == $past(pat2_i[15 -: DW]))
    else $error("alternate user pattern not taken");
  AST_SEQ_IGNORED: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R2
    sample_valid_i && chan_i.test_mode == TM_POSFS |=> data_o == '1)
    else $error("sequencing field leaked into fixed pattern");
  AST_NORMAL_DATA: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R6
    sample_valid_i && chan_i.test_mode == TM_OFF |=> data_o == $past(norm))
    else $error("normal data not restored");
endmodule : aocr_tpg

//--- rtl/aocr_regs.sv
// output test, format, drive and phase register bank behind the serial port, with pattern muxes
module aocr_regs #(
  parameter int unsigned NCH = 4,
  parameter int unsigned DW = 12
) (
  input wire logic clk_i, // 25 MHz system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic spi_sclk_i, // serial port clock pin
  input wire logic spi_csb_n_i, // serial port select pin, active low
  input wire logic spi_sdio_i, // serial data pin, input side
  output logic spi_sdio_o, // serial data pin, output side
  output logic spi_sdio_oe_o, // high while driving serial data
  input wire logic [NCH-1:0] chan_sel_i, // channels that take local writes
  input wire logic [7:0] user_pattern_one_high_i, // pattern one upper byte
  input wire logic [15:0] user_pattern_two_i, // pattern two
  input wire logic sample_valid_i, // new sample word strobe
  input wire logic [NCH*DW-1:0] sample_i, // converted samples, channel 0 low
  output aocr_pkg::aocr_cfg_s cfg_o, // global settings
  output aocr_pkg::aocr_chan_cfg_s [NCH-1:0] chan_cfg_o, // per-channel settings
  output logic [NCH*DW-1:0] data_o // words to the serializers
);
  import aocr_pkg::*;

  // pins come from the host's timing, so all three are synchronised first
  logic [2:0] sync1_q, sync2_q, prev_q;
  logic sclk_rise, sclk_fall, cs_act, sdio_s;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_q <= 3'h2;
      sync2_q <= 3'h2;
      prev_q <= 3'h2;
    end
    else
    begin
      sync1_q <= {spi_sdio_i, spi_csb_n_i, spi_sclk_i};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign cs_act = ~sync2_q[1];
  assign sdio_s = sync2_q[2];
  assign sclk_rise = cs_act & sync2_q[0] & ~prev_q[0];
  assign sclk_fall = cs_act & ~sync2_q[0] & prev_q[0];

  // register state
  logic [7:0] enh_q, tmg_q, fmt_q, drv_q, ph_q, vref_q, pat_q;
  logic [7:0] enh_d, tmg_d, fmt_d, drv_d, ph_d, vref_d, pat_d;
  logic [NCH-1:0][3:0] mode_q, mode_d;
  logic [NCH-1:0][7:0] offs_q, offs_d;
  logic [NCH-1:0] inv_q, inv_d;

  // serial port state
  aocr_spi_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic rw_q, rw_d, reload_q, reload_d, oe_q, oe_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] rd_sh_q, rd_sh_d;
  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  int unsigned sel_idx;

  // local reads show the lowest selected channel
  always_comb
  begin
    sel_idx = 0;
    for (int i = NCH - 1; i >= 0; i--)
      if (chan_sel_i[i])
        sel_idx = i;
  end

  function automatic logic [7:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_ENH: r = enh_q;
      ADDR_TEST: r = tmg_q | {4'h0, mode_q[sel_idx]};
      ADDR_OFFS: r = offs_q[sel_idx];
      ADDR_FMT: r = fmt_q | (8'(inv_q[sel_idx]) << INV_BIT);
      ADDR_DRV: r = drv_q;
      ADDR_PHASE: r = ph_q;
      ADDR_VREF: r = vref_q;
      ADDR_PAT1L: r = pat_q;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_mux

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    addr_d = addr_q;
    rd_sh_d = rd_sh_q;
    reload_d = reload_q;
    oe_d = oe_q;
    wr_stb = 1'b0;
    wr_addr = addr_q;
    wr_data = {sh_q[6:0], sdio_s};
    if (!cs_act)
    begin
      st_d = SPI_IDLE;
      oe_d = 1'b0;
      reload_d = 1'b0;
    end
    else
    begin
      case (st_q)
        SPI_IDLE:
        begin
          st_d = SPI_INSTR;
          cnt_d = 4'h0;
        end
        SPI_INSTR:
        begin
          if (sclk_rise)
          begin
            sh_d = {sh_q[14:0], sdio_s};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == INSTR_LAST)
            begin
              st_d = SPI_DATA;
              cnt_d = 4'h0;
              rw_d = sh_d[RW_BIT];
              addr_d = sh_d[ADDR_W-1:0];
              rd_sh_d = rd_mux(sh_d[ADDR_W-1:0]);
              oe_d = sh_d[RW_BIT];
            end
          end
        end
        SPI_DATA:
        begin
          if (sclk_rise)
          begin
            sh_d = {sh_q[14:0], sdio_s};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == BYTE_LAST)
            begin
              cnt_d = 4'h0;
              wr_stb = ~rw_q;
              addr_d = addr_q - 1'b1;
              reload_d = rw_q;
            end
          end
          else if (sclk_fall && rw_q)
          begin
            rd_sh_d = reload_q ? rd_mux(addr_q) : {rd_sh_q[6:0], 1'b0};
            reload_d = 1'b0;
          end
        end
        default: st_d = SPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_q <= SPI_IDLE;
      cnt_q <= 4'h0;
      sh_q <= '0;
      rw_q <= 1'b0;
      addr_q <= '0;
      rd_sh_q <= 8'h00;
      reload_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      addr_q <= addr_d;
      rd_sh_q <= rd_sh_d;
      reload_q <= reload_d;
      oe_q <= oe_d;
    end
  end

  assign spi_sdio_o = rd_sh_q[7];
  assign spi_sdio_oe_o = oe_q;

  // only documented bits are kept; open bits read back as zero
  always_comb
  begin
    enh_d = enh_q;
    tmg_d = tmg_q;
    fmt_d = fmt_q;
    drv_d = drv_q;
    ph_d = ph_q;
    vref_d = vref_q;
    pat_d = pat_q;
    mode_d = mode_q;
    offs_d = offs_q;
    inv_d = inv_q;
    if (wr_stb)
    begin
      case (wr_addr)
        ADDR_ENH: enh_d = wr_data & (8'h01 << CHOP_BIT);
        ADDR_TEST: tmg_d = wr_data & 8'hf0;
        ADDR_FMT: fmt_d = wr_data & ((8'h01 << IEEE_BIT) | (8'h01 << TWOS_BIT));
        ADDR_DRV: drv_d = wr_data & ((8'h03 << TERM_LSB) | (8'h01 << DRV_BIT)); // R5
        ADDR_PHASE: ph_d = wr_data & 8'h7f; // R4
        ADDR_VREF: vref_d = wr_data & 8'h07;
        ADDR_PAT1L: pat_d = wr_data;
        default: pat_d = pat_q;
      endcase
      for (int i = 0; i < NCH; i++)
        if (chan_sel_i[i])
        begin
          if (wr_addr == ADDR_TEST)
            mode_d[i] = wr_data[3:0]; // R3
          if (wr_addr == ADDR_OFFS)
            offs_d[i] = wr_data;
          if (wr_addr == ADDR_FMT)
            inv_d[i] = wr_data[INV_BIT];
        end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      enh_q <= RST_ENH;
      tmg_q <= RST_TEST;
      fmt_q <= RST_FMT;
      drv_q <= RST_DRV;
      ph_q <= RST_PHASE;
      vref_q <= RST_VREF;
      pat_q <= RST_PAT1L;
      mode_q <= '0;
      offs_q <= {NCH{RST_OFFS}};
      inv_q <= '0;
    end
    else
    begin
      enh_q <= enh_d;
      tmg_q <= tmg_d;
      fmt_q <= fmt_d;
      drv_q <= drv_d;
      ph_q <= ph_d;
      vref_q <= vref_d;
      pat_q <= pat_d;
      mode_q <= mode_d;
      offs_q <= offs_d;
      inv_q <= inv_d;
    end
  end

  always_comb
  begin
    cfg_o.chop_en = enh_q[CHOP_BIT];
    cfg_o.ieee_range = fmt_q[IEEE_BIT];
    cfg_o.twos_comp = fmt_q[TWOS_BIT];
    cfg_o.drive_double = drv_q[DRV_BIT]; // R5
    cfg_o.term_sel = drv_q[TERM_LSB +: 2];
    cfg_o.clk_phase_in = ph_q[PH_IN_LSB +: 3]; // R4
    cfg_o.clk_phase_out = ph_q[3:0];
    cfg_o.vref_sel = vref_q[2:0];
    cfg_o.pat_seq = tmg_q[SEQ_LSB +: 2];
    cfg_o.pn_long_rst = tmg_q[PNL_BIT];
    cfg_o.pn_short_rst = tmg_q[PNS_BIT];
    cfg_o.user_pattern_one_low = pat_q;
    for (int i = 0; i < NCH; i++)
    begin
      chan_cfg_o[i].test_mode = mode_q[i];
      chan_cfg_o[i].offset_trim = offs_q[i];
      chan_cfg_o[i].invert = inv_q[i];
    end
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_chan
    aocr_tpg #(.DW(DW)) u_tpg (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .sample_valid_i(sample_valid_i),
      .sample_i(sample_i[g*DW +: DW]),
      .chan_i(chan_cfg_o[g]),
      .cfg_i(cfg_o),
      .pat1_i({user_pattern_one_high_i, pat_q}),
      .pat2_i(user_pattern_two_i),
      .data_o(data_o[g*DW +: DW])
    );
  end

  sequence s_byte_write(logic [ADDR_W-1:0] a);
    wr_stb && wr_addr == a;
  endsequence

  AST_PHASE_FIELD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R4
    s_byte_write(ADDR_PHASE) |=> cfg_o.clk_phase_in == $past(wr_data[6:4]) ##1 $stable(cfg_o.clk_phase_in))
    else $error("input clock phase field not taken from bits 6 to 4");
  AST_DRIVE_BIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R5
    s_byte_write(ADDR_DRV) |=> cfg_o.drive_double == $past(wr_data[0]))
    else $error("drive strength does not follow bit 0");
  AST_USER_CODE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R3
    s_byte_write(ADDR_TEST) ##0 (chan_sel_i[0] && wr_data[3:0] == TM_USER)
    |=> chan_cfg_o[0].test_mode == TM_USER)
    else $error("user pattern code not stored");
  AST_OE_READ_ONLY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    spi_sdio_oe_o |-> rw_q && st_q == SPI_DATA)
    else $error("data pin driven outside a read");
endmodule : aocr_regs

//--- dv/aocr_spi_host.sv
// serial port host model that frames register reads and writes
module aocr_spi_host (
  input wire logic clk_i, // system clock
  input wire logic sdio_i, // resolved serial data line
  output logic sclk_o, // serial clock, still outside frames
  output logic csb_n_o, // select, active low
  output logic sdio_o, // host data bit
  output logic sdio_oe_o // high while the host drives the data line
);
  timeunit 1ns;
  timeprecision 1ps;
  // six cycles a phase keeps clear of the four-cycle synchroniser minimum
  localparam int HALF = 6;

  initial
  begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_cyc

  // one instruction and one data byte, msb first; read bits taken just before each fall
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdat, output logic [7:0] rdat);
    logic [23:0] frame;
    logic rd_bit;
    frame = {rd, 2'h0, addr, wdat};
    rdat = 8'h00;
    @(posedge clk_i);
    csb_n_o <= 1'b0;
    wait_cyc(4);
    for (int i = 23; i >= 0; i--)
    begin
      rd_bit = rd && (i < 8);
      sdio_oe_o <= !rd_bit;
      sdio_o <= rd_bit ? 1'b0 : frame[i];
      wait_cyc(HALF);
      sclk_o <= 1'b1;
      wait_cyc(HALF);
      // the port loads a read byte on the last instruction rise and shifts a few cycles after each fall
      if (rd && i >= 1 && i <= 8)
        rdat[i-1] = sdio_i;
      sclk_o <= 1'b0;
    end
    wait_cyc(HALF);
    csb_n_o <= 1'b1;
    sdio_oe_o <= 1'b0;
    wait_cyc(8);
  endtask : xfer
endmodule : aocr_spi_host

//--- dv/tb.sv
// self-checking bench for the output test and configuration register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aocr_pkg::*;
  localparam int unsigned NCH = 4;
  localparam int unsigned DW = 12;
  localparam logic [12:0] ADDRS [8] = '{13'h000c, 13'h000d, 13'h0010, 13'h0014, 13'h0015, 13'h0016, 13'h0018,
                                        13'h0019};
  localparam logic [7:0] RSTV [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h04, 8'h00};
  // open bits read back as zero
  localparam logic [7:0] MASK [8] = '{8'h04, 8'hff, 8'hff, 8'h45, 8'h31, 8'h7f, 8'h07, 8'hff};
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sclk, csb_n, host_sdio, host_oe, dev_sdio, dev_oe, sdio_line;
  logic [NCH-1:0] chan_sel = 4'hf;
  logic [7:0] pat1_high = 8'h3c;
  logic [15:0] pat2 = 16'h1234;
  logic sample_valid = 1'b0;
  logic [NCH*DW-1:0] sample = 48'h0;
  aocr_cfg_s cfg;
  aocr_chan_cfg_s [NCH-1:0] chan_cfg;
  logic [NCH*DW-1:0] data;
  int error_cnt = 0;
  int compares = 0;

  always #20 clk_i = ~clk_i;
  // the pin has a pull-down, so a released line reads low
  assign sdio_line = dev_oe ? dev_sdio : (host_oe ? host_sdio : 1'b0);

  aocr_regs #(.NCH(NCH), .DW(DW)) uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .spi_sclk_i(sclk), .spi_csb_n_i(csb_n), .spi_sdio_i(sdio_line),
    .spi_sdio_o(dev_sdio), .spi_sdio_oe_o(dev_oe), .chan_sel_i(chan_sel), .user_pattern_one_high_i(pat1_high),
    .user_pattern_two_i(pat2), .sample_valid_i(sample_valid), .sample_i(sample), .cfg_o(cfg),
    .chan_cfg_o(chan_cfg), .data_o(data)
  );

  aocr_spi_host host (
    .clk_i(clk_i), .sdio_i(sdio_line), .sclk_o(sclk), .csb_n_o(csb_n), .sdio_o(host_sdio), .sdio_oe_o(host_oe)
  );

  task automatic close_out;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic chk_word(input string what, input logic [NCH*DW-1:0] exp, input logic [NCH*DW-1:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic wr(input logic [12:0] addr, input logic [7:0] val);
    logic [7:0] unused;
    host.xfer(1'b0, addr, val, unused);
  endtask : wr

  task automatic rd_chk(input logic [12:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    host.xfer(1'b1, addr, 8'h00, got);
    chk_byte($sformatf("register %h", addr), exp, got);
  endtask : rd_chk

  // one sample pulse; the output word is registered on the edge that takes it
  task automatic send(input logic [NCH*DW-1:0] s, output logic [NCH*DW-1:0] got);
    @(posedge clk_i);
    sample <= s;
    sample_valid <= 1'b1;
    @(posedge clk_i);
    sample_valid <= 1'b0;
    #1;
    got = data;
  endtask : send

  task automatic t_reset;
    for (int i = 0; i < 8; i++)
      rd_chk(ADDRS[i], RSTV[i]);
  endtask : t_reset

  task automatic t_rw;
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDRS[i], 8'hff);
      rd_chk(ADDRS[i], MASK[i]);
      wr(ADDRS[i], 8'h00);
      rd_chk(ADDRS[i], 8'h00);
    end
    wr(13'h0011, 8'hff);
    rd_chk(13'h0011, 8'h00);
    @(posedge clk_i);
    chan_sel <= 4'h0;
    wr(13'h0010, 8'h77);
    @(posedge clk_i);
    chan_sel <= 4'hf;
    rd_chk(13'h0010, 8'h00);
  endtask : t_rw

  task automatic t_drive_phase;
    wr(13'h0015, 8'h01);
    chk_byte("drive_double", 8'h01, {7'h00, cfg.drive_double});
    wr(13'h0015, 8'h00);
    chk_byte("drive_double", 8'h00, {7'h00, cfg.drive_double});
    wr(13'h0016, 8'h53);
    chk_byte("clk_phase_in", 8'h05, {5'h00, cfg.clk_phase_in});
    chk_byte("clk_phase_out", 8'h03, {4'h0, cfg.clk_phase_out});
    wr(13'h0016, 8'h03);
  endtask : t_drive_phase

  task automatic t_patterns;
    logic [NCH*DW-1:0] a, b;
    logic [7:0] codes [5];
    logic [DW-1:0] words [5];
    codes = '{8'h41, 8'h42, 8'h43, 8'h25, 8'h16};
    words = '{12'h800, 12'hfff, 12'h000, 12'hfff, 12'h1ff};
    wr(13'h0019, 8'ha5);
    chk_byte("user_pattern_one_low", 8'ha5, cfg.user_pattern_one_low);
    wr(13'h0014, 8'h00);
    send(48'h123456789abc, a);
    chk_word("normal data", 48'h123456789abc, a);
    wr(13'h000d, 8'h08);
    chk_byte("test_mode", 8'h08, {4'h0, chan_cfg[3].test_mode});
    send(48'h0, a);
    send(48'h0, b);
    chk_word("user single", {4{12'h3ca}}, a);
    chk_word("user single", {4{12'h3ca}}, b);
    wr(13'h000d, 8'h48);
    send(48'h0, a);
    send(48'h0, b);
    chk_word("user alternate", {4{12'h3ca}}, a);
    chk_word("user alternate", {4{12'h123}}, b);
    wr(13'h000d, 8'h88);
    send(48'h0, a);
    send(48'h0, b);
    chk_word("user single once", {4{12'h3ca}}, a);
    chk_word("user single once", 48'h0, b);
    for (int i = 0; i < 5; i++)
    begin
      wr(13'h000d, codes[i]);
      send(48'h5a5a5a5a5a5a, a);
      send(48'h5a5a5a5a5a5a, b);
      chk_word("fixed pattern", {4{words[i]}}, a);
      chk_word("fixed pattern", {4{words[i]}}, b);
    end
    wr(13'h000d, 8'h00);
    send(48'hfedcba987654, a);
    chk_word("normal data", 48'hfedcba987654, a);
    // twos complement flips the msb, then invert flips every bit
    wr(13'h0014, 8'h05);
    send(48'hfedcba987654, a);
    chk_word("twos inverted data", 48'h812b45e781ab, a);
  endtask : t_patterns

  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_rw();
    t_drive_phase();
    t_patterns();
    close_out();
  end

  // about sixty frames of roughly 310 cycles each fit well inside this span
  initial
  begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end
endmodule : tb
